/* rtl/microcore_cond_jump_unit.sv */
/*
  Conditional jump unit of a microcore: decodes three conditional jumps,
  keeps the program counter, and holds control and jump registers on Avalon-MM.
  Assumes instruction words arrive on clk; feedback levels are asynchronous.
*/
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`include "cond_jump_params.svh"
`default_nettype none
module microcore_cond_jump_unit #(
  parameter int PC_W = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire cond_jump_pkg::word_t instr_word,
  input wire logic instr_valid,
  input wire cond_jump_pkg::word_t drv_feedback,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [PC_W-1:0] core_program_counter,
  output logic jump_taken,
  output logic instr_done
);
  import cond_jump_pkg::*;

  function automatic jump_kind_t decode(input word_t w);
    if (w[`OPC_HI:`OPC_LO] == `OPC_REL_CR) begin
      decode = JK_REL_CR;
    end else if (w[`OPC_HI:`OPC_LO] == `OPC_ABS_FBK && w[`TAIL_HI:0] == `ABS_FBK_TAIL) begin
      decode = JK_ABS_FBK;
    end else if (w[`OPC_HI:`OPC_LO] == `OPC_REL_FBK) begin
      decode = JK_REL_FBK;
    end else begin
      decode = JK_NONE;
    end
  endfunction

  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc, input word_t w);
    logic [PC_W-1:0] ofs;
    ofs = PC_W'($signed(w[`OFS_HI:`OFS_LO]));
    rel_target = pc + ofs;
  endfunction

  // feedback levels come from analog comparators, so two flops first
  word_t fbk_meta_r, fbk_sync_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fbk_meta_r <= 16'h0000;
      fbk_sync_r <= 16'h0000;
    end else begin
      fbk_meta_r <= drv_feedback;
      fbk_sync_r <= fbk_meta_r;
    end
  end

  // register file state
  word_t core_a_control_register_r, core_a_control_register_nxt;
  word_t core_b_control_register_r, core_b_control_register_nxt;
  logic [PC_W-1:0] jump_target_registers_r [2];
  logic [PC_W-1:0] jump_target_registers_nxt [2];
  logic core_sel_r, core_sel_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;

  // program counter state
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic taken_r, taken_nxt;
  logic done_r, done_nxt;

  cond_sel_if cs ();
  cond_select u_sel (
    .cs(cs)
  );

  jump_kind_t kind;
  logic cond_ok;

  always_comb begin
    kind = decode(instr_word);
    // control bit comes from whichever core this unit serves
    cs.ctrl_word = core_sel_r ? core_b_control_register_r : core_a_control_register_r;
    cs.fbk_word = fbk_sync_r;
    cs.ctrl_bit_selector = instr_word[`SEL_HI:`SEL_LO];
    cs.feedback_selector = instr_word[`SEL_HI:`SEL_LO];
    cs.polarity = instr_word[`POL_BIT];
    cond_ok = (kind == JK_REL_CR) ? cs.ctrl_cond : cs.fbk_cond;
  end

  always_comb begin
    pc_nxt = pc_r;
    taken_nxt = 1'b0;
    done_nxt = 1'b0;
    if (instr_valid) begin
      done_nxt = 1'b1;
      pc_nxt = pc_r + PC_W'(1);
      if (kind != JK_NONE && cond_ok) begin
        taken_nxt = 1'b1;
        if (kind == JK_ABS_FBK) begin
          pc_nxt = jump_target_registers_r[instr_word[`TREG_BIT]];
        end else begin
          pc_nxt = rel_target(pc_r, instr_word);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_r <= PC_W'(`PC_RST);
      taken_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      taken_r <= taken_nxt;
      done_r <= done_nxt;
    end
  end

  // one wait state per access: request seen, answer on the next edge
  logic wr_go;
  always_comb begin
    wr_go = avs_write && !wait_r;
    core_a_control_register_nxt = core_a_control_register_r;
    core_b_control_register_nxt = core_b_control_register_r;
    jump_target_registers_nxt = jump_target_registers_r;
    core_sel_nxt = core_sel_r;
    wait_nxt = !((avs_read || avs_write) && wait_r);
    rdata_nxt = rdata_r;
    if (wr_go) begin
      if (avs_address == `ADDR_CORE_A_CTRL) begin
        core_a_control_register_nxt = avs_writedata[15:0];
      end else if (avs_address == `ADDR_CORE_B_CTRL) begin
        core_b_control_register_nxt = avs_writedata[15:0];
      end else if (avs_address == `ADDR_JUMP_REG0) begin
        jump_target_registers_nxt[0] = avs_writedata[PC_W-1:0];
      end else if (avs_address == `ADDR_JUMP_REG1) begin
        jump_target_registers_nxt[1] = avs_writedata[PC_W-1:0];
      end else if (avs_address == `ADDR_CORE_SEL) begin
        core_sel_nxt = avs_writedata[0];
      end
    end
    if (avs_read && wait_r) begin
      if (avs_address == `ADDR_CORE_A_CTRL) begin
        rdata_nxt = {16'h0000, core_a_control_register_r};
      end else if (avs_address == `ADDR_CORE_B_CTRL) begin
        rdata_nxt = {16'h0000, core_b_control_register_r};
      end else if (avs_address == `ADDR_JUMP_REG0) begin
        rdata_nxt = 32'(jump_target_registers_r[0]);
      end else if (avs_address == `ADDR_JUMP_REG1) begin
        rdata_nxt = 32'(jump_target_registers_r[1]);
      end else if (avs_address == `ADDR_CORE_SEL) begin
        rdata_nxt = {31'h0, core_sel_r};
      end else if (avs_address == `ADDR_STATUS) begin
        rdata_nxt = {15'h0, taken_r, 16'(pc_r)};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_a_control_register_r <= `CTRL_RST;
      core_b_control_register_r <= `CTRL_RST;
      jump_target_registers_r[0] <= PC_W'(`PC_RST);
      jump_target_registers_r[1] <= PC_W'(`PC_RST);
      core_sel_r <= 1'b0;
      rdata_r <= 32'h00000000;
      wait_r <= 1'b1;
    end else begin
      core_a_control_register_r <= core_a_control_register_nxt;
      core_b_control_register_r <= core_b_control_register_nxt;
      jump_target_registers_r <= jump_target_registers_nxt;
      core_sel_r <= core_sel_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign core_program_counter = pc_r;
  assign jump_taken = taken_r;
  assign instr_done = done_r;

  // independent reference for the checks below
  logic [PC_W-1:0] ref_rel, ref_ofs, ref_abs;
  logic ref_cbit, ref_fbit;
  word_t ref_cw;
  always_comb begin
    ref_ofs = {{(PC_W-5){instr_word[4]}}, instr_word[4:0]};
    ref_rel = pc_r + ref_ofs;
    ref_abs = jump_target_registers_r[instr_word[4]];
    ref_cw = core_sel_r ? core_b_control_register_r : core_a_control_register_r;
    ref_cbit = ref_cw[instr_word[8:5]];
    ref_fbit = fbk_sync_r[instr_word[8:5]];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rel_cr_hit_s;
    instr_valid && instr_word[15:10] == 6'h08 && ref_cbit == instr_word[9];
  endsequence
  sequence rel_fbk_hit_s;
    instr_valid && instr_word[15:10] == 6'h05 && ref_fbit == instr_word[9];
  endsequence

  rel_cr_jump_a: assert property (rel_cr_hit_s |=> taken_r && pc_r == $past(ref_rel))
    else $error("relative control jump target wrong");
  rel_offset_a: assert property ((rel_cr_hit_s or rel_fbk_hit_s) |=>
    PC_W'(pc_r - $past(pc_r)) == $past(ref_ofs))
    else $error("relative offset not signed five bit");
  ctrl_pol_miss_a: assert property (instr_valid && instr_word[15:10] == 6'h08 &&
    ref_cbit != instr_word[9] |=> !taken_r)
    else $error("control jump taken on wrong level");
  core_sel_a: assert property (instr_valid && instr_word[15:10] == 6'h08 &&
    core_sel_r && core_b_control_register_r[instr_word[8:5]] == instr_word[9] |=> taken_r)
    else $error("core b control bit ignored");
  abs_fbk_jump_a: assert property (instr_valid && instr_word[15:10] == 6'h0E &&
    instr_word[3:0] == 4'h4 && ref_fbit == instr_word[9] |=>
    taken_r && pc_r == $past(ref_abs))
    else $error("absolute feedback jump target wrong");
  abs_tail_a: assert property (instr_valid && instr_word[15:10] == 6'h0E &&
    instr_word[3:0] != 4'h4 |=> !taken_r)
    else $error("bad tail decoded as absolute jump");
  rel_fbk_jump_a: assert property (rel_fbk_hit_s |=> taken_r && pc_r == $past(ref_rel))
    else $error("relative feedback jump target wrong");
  seq_advance_a: assert property (instr_valid && instr_word[15:10] != 6'h08 &&
    instr_word[15:10] != 6'h05 && !(instr_word[15:10] == 6'h0E && instr_word[3:0] == 4'h4)
    |=> !taken_r && pc_r == $past(pc_r) + PC_W'(1))
    else $error("no sequential advance");
  idle_hold_a: assert property (!instr_valid |=> $stable(pc_r) && !done_r)
    else $error("pc moved without instruction");
  bus_answer_a: assert property ((avs_read || avs_write) && wait_r |=> !wait_r ##1 wait_r)
    else $error("bus answer not one wait state");
endmodule // microcore_cond_jump_unit
`default_nettype wire

/* rtl/cond_jump_params.svh */
/*
  Constants of the conditional jump unit: opcodes, field positions,
  register offsets and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef COND_JUMP_PARAMS_SVH
`define COND_JUMP_PARAMS_SVH

`define OPC_HI 15
`define OPC_LO 10
`define OPC_REL_CR 6'h08
`define OPC_ABS_FBK 6'h0E
`define OPC_REL_FBK 6'h05
`define ABS_FBK_TAIL 4'h4
`define TAIL_HI 3
`define POL_BIT 9
`define SEL_HI 8
`define SEL_LO 5
`define OFS_HI 4
`define OFS_LO 0
`define TREG_BIT 4

`define ADDR_CORE_A_CTRL 8'h00
`define ADDR_CORE_B_CTRL 8'h04
`define ADDR_JUMP_REG0 8'h08
`define ADDR_JUMP_REG1 8'h0C
`define ADDR_CORE_SEL 8'h10
`define ADDR_STATUS 8'h14

`define CTRL_RST 16'h0000
`define PC_RST 16'h0000

`endif

/* rtl/cond_jump_pkg.sv */
/*
  Types shared by the conditional jump unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cond_jump_pkg;
  typedef enum logic [1:0] {
    JK_NONE = 2'b00,
    JK_REL_CR = 2'b01,
    JK_ABS_FBK = 2'b10,
    JK_REL_FBK = 2'b11
  } jump_kind_t;
  typedef logic [15:0] word_t;
  typedef logic [3:0] sel_t;
endpackage
`default_nettype wire

/* rtl/cond_sel_if.sv */
/*
  Carrier between the jump unit and its condition selector.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface cond_sel_if;
  import cond_jump_pkg::*;
  word_t ctrl_word;
  word_t fbk_word;
  sel_t ctrl_bit_selector;
  sel_t feedback_selector;
  logic polarity;
  logic ctrl_cond;
  logic fbk_cond;
  modport unit (output ctrl_word, fbk_word, ctrl_bit_selector, feedback_selector,
    polarity, input ctrl_cond, fbk_cond);
  modport sel (input ctrl_word, fbk_word, ctrl_bit_selector, feedback_selector,
    polarity, output ctrl_cond, fbk_cond);
endinterface
`default_nettype wire

/* rtl/cond_select.sv */
/*
  Condition selector: picks one control or feedback bit and applies polarity.
  Assumes feedback word already synchronised, bit order as the selector codes.
*/
`default_nettype none
module cond_select (
  cond_sel_if.sel cs
);
  import cond_jump_pkg::*;

  // true when the bit equals the polarity level
  function automatic logic pick(input word_t w, input sel_t s, input logic pol);
    pick = (w[s] == pol);
  endfunction

  always_comb begin
    cs.ctrl_cond = pick(cs.ctrl_word, cs.ctrl_bit_selector, cs.polarity);
    cs.fbk_cond = pick(cs.fbk_word, cs.feedback_selector, cs.polarity);
  end
endmodule // cond_select
`default_nettype wire

/* tb/code_mem_model.sv */
/*
  Program memory and feedback comparator stand-in for the jump unit.
  Assumes the bench loads words on clk and sets feedback levels itself.
*/
`default_nettype none
module code_mem_model (
  input wire logic clk,
  input wire logic [9:0] pc,
  input wire logic ld_en,
  input wire logic [9:0] ld_addr,
  input wire cond_jump_pkg::word_t ld_word,
  input wire cond_jump_pkg::word_t fbk_lvl,
  output cond_jump_pkg::word_t instr_word,
  output cond_jump_pkg::word_t drv_feedback
);
  timeunit 1ns;
  timeprecision 1ps;
  import cond_jump_pkg::*;
  word_t mem [1024];
  // blank memory holds a non-jump word, so a stray fetch just steps on
  initial foreach (mem[i]) mem[i] = 16'h0000;
  always @(posedge clk) begin
    if (ld_en) mem[ld_addr] <= ld_word;
  end
  assign instr_word = mem[pc];
  // comparator levels change slowly; the unit resynchronises them
  assign drv_feedback = fbk_lvl;
endmodule // code_mem_model
`default_nettype wire

/* tb/microcore_cond_jump_unit_bench.sv */
/*
  Self-checking bench of the conditional jump unit: Avalon register
  access, all three conditional jumps over every selector and polarity.
  Assumes the unit and code_mem_model are compiled first.
*/
`default_nettype none
module microcore_cond_jump_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cond_jump_pkg::*;
  localparam int PW = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  word_t instr_word, drv_feedback;
  word_t ld_word = 16'h0000;
  word_t fbk_lvl = 16'h0000;
  logic instr_valid = 1'b0;
  logic ld_en = 1'b0;
  logic [9:0] ld_addr = 10'h000;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, jump_taken, instr_done;
  logic [PW-1:0] pc;
  logic [PW-1:0] exp_pc = 10'h000;
  int err_total = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  microcore_cond_jump_unit #(.PC_W(PW)) dut (.clk(clk), .rst(rst), .instr_word(instr_word),
    .instr_valid(instr_valid), .drv_feedback(drv_feedback), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_program_counter(pc), .jump_taken(jump_taken), .instr_done(instr_done));
  code_mem_model mem (.clk(clk), .pc(pc), .ld_en(ld_en), .ld_addr(ld_addr),
    .ld_word(ld_word), .fbk_lvl(fbk_lvl), .instr_word(instr_word),
    .drv_feedback(drv_feedback));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      check(32'h1, 32'h0);
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  function automatic logic [PW-1:0] rel(input word_t w);
    return exp_pc + {{5{w[4]}}, w[4:0]};
  endfunction
  // word is placed at the expected pc, then executed for one cycle
  task automatic run(input word_t w, input logic take, input logic [PW-1:0] tgt);
    @(posedge clk);
    ld_en <= 1'b1;
    ld_addr <= exp_pc;
    ld_word <= w;
    @(posedge clk);
    ld_en <= 1'b0;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    exp_pc = take ? tgt : exp_pc + 10'h001;
    @(negedge clk);
    check({22'h0, pc}, {22'h0, exp_pc});
    check({31'h0, jump_taken}, {31'h0, take});
    check({31'h0, instr_done}, 32'h1);
    // both flags are one-cycle pulses and pc holds while idle
    @(negedge clk);
    check({30'h0, jump_taken, instr_done}, 32'h0);
    check({22'h0, pc}, {22'h0, exp_pc});
  endtask
  initial begin
    word_t w, ctl;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({22'h0, pc}, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h00, 32'h0000A5C3);
    wr(8'h04, 32'h00003C5A);
    wr(8'h08, 32'h000002AB);
    wr(8'h0C, 32'h000000F0);
    rd(8'h04, 32'h00003C5A);
    rd(8'h08, 32'h000002AB);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0);
    for (int core = 0; core < 2; core++) begin
      wr(8'h10, 32'(core));
      ctl = core ? 16'h3C5A : 16'hA5C3;
      for (int k = 0; k < 32; k++) begin
        w = {6'h08, k[0], k[4:1], k[4:0]};
        run(w, ctl[k[4:1]] == k[0], rel(w));
      end
    end
    // feedback passes a two-flop synchroniser before it can steer a jump
    @(posedge clk);
    fbk_lvl <= 16'h5A3C;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 32; k++) begin
      w = {6'h05, k[0], k[4:1], ~k[4:0]};
      run(w, fbk_lvl[k[4:1]] == k[0], rel(w));
      w = {6'h0E, k[0], k[4:1], k[1], 4'h4};
      run(w, fbk_lvl[k[4:1]] == k[0], k[1] ? 10'h0F0 : 10'h2AB);
    end
    run({6'h0E, 1'b0, 4'h0, 1'b0, 4'h5}, 1'b0, 10'h000);
    rd(8'h14, {22'h0, exp_pc});
    rst <= 1'b1;
    @(negedge clk);
    check({22'h0, pc}, 32'h0);
    check({31'h0, avs_waitrequest}, 32'h1);
    stop_test();
  end
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule // microcore_cond_jump_unit_bench
`default_nettype wire
